// ### pkg/fsp_pkg.sv
package fsp_pkg;

  // ***************************************************************
  // Register offsets (byte addresses on AXI4-Lite)
  // ***************************************************************
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_ADDR   = 8'h04;
  localparam logic [7:0] OFF_WDATA  = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_IRQ_ST = 8'h10;
  localparam logic [7:0] OFF_IRQ_MK = 8'h14;
  localparam logic [7:0] OFF_RDATA  = 8'h18;

  // ***************************************************************
  // Command codes written to the control register
  // ***************************************************************
  localparam logic [2:0] CMD_READ   = 3'h1;
  localparam logic [2:0] CMD_WRITE  = 3'h2;
  localparam logic [2:0] CMD_POLL   = 3'h3;
  localparam logic [2:0] CMD_ERASE  = 3'h4;

  // ***************************************************************
  // Flash status bit positions on the data bus
  // ***************************************************************
  localparam int POS_POLARITY = 7;
  localparam int POS_GTOGGLE  = 6;
  localparam int POS_TIMEOUT  = 5;
  localparam int POS_WINDOW   = 3;
  localparam int POS_STOGGLE  = 2;

  // ***************************************************************
  // Interrupt status bits
  // ***************************************************************
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_REJ  = 2;

  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  // ***************************************************************
  // Bus cycle timing
  // ***************************************************************
  localparam int CLK_NS       = 50;
  localparam int T_CYCLE_NS   = 100;
  localparam int CYC_STROBE   = (T_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_WINDOW_US  = 50;
  localparam int CYC_WINDOW   = (T_WINDOW_US * 1000) / CLK_NS;
  // Extra hold cycles after the strobe; the data bus floats once released
  localparam int CYC_HOLD     = 0;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_EVAL
  } fsp_bus_st_t;

  typedef enum logic [2:0] {
    OP_NONE, OP_READ, OP_WRITE, OP_POLL1, OP_POLL2, OP_RECHK, OP_PRE,
    OP_POST
  } fsp_op_t;

endpackage : fsp_pkg

// ### core/fsp_ctrl.sv
// Summary of operation
// - After failure, host writes reset command.
// - Skip window check only under 50 us.
// - Confirm acceptance by toggle before window; CMD_ERASE only reads the window bit.
// - Check window before and after command.
// - Status reads use address inside sector.
// - Two consecutive reads decide toggling.
// - Recheck toggle when timeout flag rises.
`timescale 1ns/100ps
`default_nettype none
module fsp_ctrl (
  // AXI4-Lite slave
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // Interrupt
  output logic             irq,
  // Flash pins
  output logic [19:0]      fl_addr,
  output logic             fl_ce_n,
  output logic             fl_oe_n,
  output logic             fl_we_n,
  output logic [15:0]      fl_dq_o,
  output logic             fl_dq_oe,
  input  wire logic [15:0] fl_dq_i,
  input  wire logic        ready_busy_out
);

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  logic [15:0] dq_s1_q, dq_s2_q, dq_s3_q;
  logic [2:0]  rb_q;
  logic        rb_st_q;
  always_ff @(posedge aclk) begin
    dq_s1_q <= fl_dq_i;
    dq_s2_q <= dq_s1_q;
    dq_s3_q <= dq_s2_q;
    rb_q    <= {rb_q[1:0], ready_busy_out};
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rb_st_q <= 1'b1;
    end else if (rb_q[1] == rb_q[2]) begin
      rb_st_q <= rb_q[2];
    end
  end
  wire flash_busy = !rb_st_q;

  // ***************************************************************
  // Registers and bus slave
  // ***************************************************************
  logic [19:0] addr_q;
  logic [15:0] wdata_q, rdata_q, first_q;
  logic [2:0]  cmd_q;
  logic [2:0]  ist_q, imk_q;
  logic        busy_q, fail_q, toggling_q, window_q, rej_q;
  logic        aw_q, w_q;
  logic [7:0]  awa_q;
  logic [31:0] wd_q;
  logic        bvalid_q, rvalid_q;
  logic [31:0] rdat_q;

  assign s_awready = !aw_q && !bvalid_q;
  assign s_wready  = !w_q && !bvalid_q;
  assign s_bvalid  = bvalid_q;
  assign s_bresp   = 2'b00;
  assign s_arready = !rvalid_q;
  assign s_rvalid  = rvalid_q;
  assign s_rdata   = rdat_q;
  assign s_rresp   = 2'b00;

  wire        wr_go   = aw_q && w_q && !bvalid_q;
  wire        rd_go   = s_arvalid && !rvalid_q;
  wire        cmd_hit = wr_go && awa_q == fsp_pkg::OFF_CTRL && !busy_q;
  wire [31:0] st_word = {26'h000_0000, rej_q, window_q, toggling_q,
                         fail_q, flash_busy, busy_q};
  wire [31:0] rd_mux  =
    (s_araddr == fsp_pkg::OFF_CTRL)   ? {29'h0000_0000, cmd_q} :
    (s_araddr == fsp_pkg::OFF_ADDR)   ? {12'h000, addr_q} :
    (s_araddr == fsp_pkg::OFF_WDATA)  ? {16'h0000, wdata_q} :
    (s_araddr == fsp_pkg::OFF_STATUS) ? st_word :
    (s_araddr == fsp_pkg::OFF_IRQ_ST) ? {29'h0000_0000, ist_q} :
    (s_araddr == fsp_pkg::OFF_IRQ_MK) ? {29'h0000_0000, imk_q} :
    (s_araddr == fsp_pkg::OFF_RDATA)  ? {16'h0000, rdata_q} :
    fsp_pkg::RST_ZERO;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awa_q    <= 8'h00;
      wd_q     <= fsp_pkg::RST_ZERO;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdat_q   <= fsp_pkg::RST_ZERO;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_q  <= 1'b1;
        awa_q <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_q  <= 1'b1;
        wd_q <= s_wdata;
      end
      if (wr_go) begin
        aw_q     <= 1'b0;
        w_q      <= 1'b0;
        bvalid_q <= 1'b1;
      end else if (s_bready) begin
        bvalid_q <= 1'b0;
      end
      if (rd_go) begin
        rvalid_q <= 1'b1;
        rdat_q   <= rd_mux;
      end else if (s_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Flash bus sequencer
  // ***************************************************************
  fsp_pkg::fsp_bus_st_t st_q;
  fsp_pkg::fsp_op_t     op_q;
  logic [15:0]          tmr_q;
  logic                 ev_done, ev_fail, ev_rej;

  wire tmr_end = tmr_q == 16'h0000;
  wire is_wr   = op_q == fsp_pkg::OP_WRITE;
  wire tg_now  = dq_s3_q[fsp_pkg::POS_GTOGGLE];
  wire tg_diff = tg_now != first_q[fsp_pkg::POS_GTOGGLE];
  wire tmo_now = dq_s3_q[fsp_pkg::POS_TIMEOUT];
  wire win_now = dq_s3_q[fsp_pkg::POS_WINDOW];

  assign fl_addr  = addr_q;
  // Chip select stays low through hold so the write edge lands while selected
  assign fl_ce_n  = !(st_q == fsp_pkg::ST_SETUP ||
                      st_q == fsp_pkg::ST_STROBE ||
                      st_q == fsp_pkg::ST_HOLD);
  assign fl_oe_n  = !(st_q == fsp_pkg::ST_STROBE && !is_wr);
  assign fl_we_n  = !(st_q == fsp_pkg::ST_STROBE && is_wr);
  assign fl_dq_oe = is_wr && st_q != fsp_pkg::ST_IDLE;
  assign fl_dq_o  = wdata_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q       <= fsp_pkg::ST_IDLE;
      op_q       <= fsp_pkg::OP_NONE;
      tmr_q      <= 16'h0000;
      busy_q     <= 1'b0;
      cmd_q      <= 3'h0;
      addr_q     <= 20'h0_0000;
      wdata_q    <= 16'h0000;
      rdata_q    <= 16'h0000;
      first_q    <= 16'h0000;
      fail_q     <= 1'b0;
      toggling_q <= 1'b0;
      window_q   <= 1'b0;
      rej_q      <= 1'b0;
    end else begin
      if (wr_go && !busy_q && awa_q == fsp_pkg::OFF_ADDR) begin
        addr_q <= wd_q[19:0];
      end
      if (wr_go && !busy_q && awa_q == fsp_pkg::OFF_WDATA) begin
        wdata_q <= wd_q[15:0];
      end
      if (!tmr_end) begin
        tmr_q <= tmr_q - 16'h0001;
      end
      unique case (st_q)
        fsp_pkg::ST_IDLE: begin
          if (cmd_hit && wd_q[2:0] != 3'h0) begin
            busy_q <= 1'b1;
            cmd_q  <= wd_q[2:0];
            st_q   <= fsp_pkg::ST_SETUP;
            tmr_q  <= 16'(fsp_pkg::CYC_STROBE);
            unique case (wd_q[2:0])
              fsp_pkg::CMD_WRITE: op_q <= fsp_pkg::OP_WRITE;
              fsp_pkg::CMD_POLL:  op_q <= fsp_pkg::OP_POLL1;
              fsp_pkg::CMD_ERASE: op_q <= fsp_pkg::OP_PRE;
              default:            op_q <= fsp_pkg::OP_READ;
            endcase
          end
        end
        fsp_pkg::ST_SETUP: begin
          st_q  <= fsp_pkg::ST_STROBE;
          tmr_q <= 16'(fsp_pkg::CYC_STROBE);
        end
        fsp_pkg::ST_STROBE: begin
          if (tmr_end) begin
            st_q  <= fsp_pkg::ST_HOLD;
            tmr_q <= 16'(fsp_pkg::CYC_HOLD);
          end
        end
        fsp_pkg::ST_HOLD: begin
          // Sample while stages two and three still hold strobed data
          if (tmr_end) begin
            st_q <= fsp_pkg::ST_EVAL;
          end
        end
        default: begin
          rdata_q <= dq_s3_q;
          st_q    <= fsp_pkg::ST_SETUP;
          unique case (op_q)
            fsp_pkg::OP_POLL1: begin
              first_q <= dq_s3_q;
              op_q    <= fsp_pkg::OP_POLL2;
            end
            fsp_pkg::OP_POLL2: begin
              if (tg_diff && tmo_now) begin
                first_q <= dq_s3_q;
                op_q    <= fsp_pkg::OP_RECHK;
              end else begin
                toggling_q <= tg_diff;
                fail_q     <= 1'b0;
                op_q       <= fsp_pkg::OP_NONE;
                st_q       <= fsp_pkg::ST_IDLE;
              end
            end
            fsp_pkg::OP_RECHK: begin
              toggling_q <= tg_diff;
              fail_q     <= tg_diff;
              op_q       <= fsp_pkg::OP_NONE;
              st_q       <= fsp_pkg::ST_IDLE;
            end
            fsp_pkg::OP_PRE: begin
              window_q <= win_now;
              op_q     <= fsp_pkg::OP_WRITE;
            end
            fsp_pkg::OP_WRITE: begin
              if (cmd_q == fsp_pkg::CMD_ERASE) begin
                op_q <= fsp_pkg::OP_POST;
              end else begin
                op_q <= fsp_pkg::OP_NONE;
                st_q <= fsp_pkg::ST_IDLE;
              end
            end
            fsp_pkg::OP_POST: begin
              window_q <= win_now;
              rej_q    <= win_now;
              op_q     <= fsp_pkg::OP_NONE;
              st_q     <= fsp_pkg::ST_IDLE;
            end
            default: begin
              op_q <= fsp_pkg::OP_NONE;
              st_q <= fsp_pkg::ST_IDLE;
            end
          endcase
        end
      endcase
      if (st_q == fsp_pkg::ST_EVAL &&
          (op_q == fsp_pkg::OP_NONE || op_q == fsp_pkg::OP_READ ||
           (op_q == fsp_pkg::OP_WRITE && cmd_q != fsp_pkg::CMD_ERASE) ||
           op_q == fsp_pkg::OP_POST || op_q == fsp_pkg::OP_RECHK ||
           (op_q == fsp_pkg::OP_POLL2 && !(tg_diff && tmo_now)))) begin
        busy_q <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Interrupts
  // ***************************************************************
  wire last_eval = st_q == fsp_pkg::ST_EVAL && busy_q;
  assign ev_done = last_eval && (op_q == fsp_pkg::OP_POLL2 ||
                   op_q == fsp_pkg::OP_RECHK) && !tg_diff;
  assign ev_fail = last_eval && op_q == fsp_pkg::OP_RECHK && tg_diff;
  assign ev_rej  = last_eval && op_q == fsp_pkg::OP_POST && win_now;
  wire [2:0] ev_v   = {ev_rej, ev_fail, ev_done};
  wire       st_wr  = wr_go && awa_q == fsp_pkg::OFF_IRQ_ST;
  wire [2:0] clr_v  = st_wr ? wd_q[2:0] : 3'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ist_q <= 3'h0;
      imk_q <= 3'h0;
    end else begin
      ist_q <= (ist_q & ~clr_v) | ev_v;
      if (wr_go && awa_q == fsp_pkg::OFF_IRQ_MK) begin
        imk_q <= wd_q[2:0];
      end
    end
  end
  assign irq = |(ist_q & imk_q);

  // ***************************************************************
  // Checks
  // ***************************************************************
  sequence s_eval_rechk;
    st_q == fsp_pkg::ST_EVAL && op_q == fsp_pkg::OP_RECHK;
  endsequence

  a_fail_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
    s_eval_rechk ##0 tg_diff |=> fail_q)
    else $error("fail flag not set after toggling recheck");
  a_fail_irq_once: assert property (@(posedge aclk) disable iff (!aresetn)
    ev_fail |=> ist_q[fsp_pkg::IRQ_FAIL])
    else $error("fail event lost");
  a_window_reject: assert property (@(posedge aclk) disable iff (!aresetn)
    ev_rej |=> rej_q && window_q)
    else $error("rejection not reported");
  a_recheck_path: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == fsp_pkg::ST_EVAL && op_q == fsp_pkg::OP_POLL2 && tg_diff
    && tmo_now |=> op_q == fsp_pkg::OP_RECHK)
    else $error("no recheck after timeout flag");
  a_strobe_len: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(fl_oe_n) |-> !fl_oe_n [*3])
    else $error("read strobe too short");
  a_we_data_out: assert property (@(posedge aclk) disable iff (!aresetn)
    !fl_we_n |-> fl_dq_oe && !fl_ce_n)
    else $error("write strobe without data drive");
  a_no_oe_we: assert property (@(posedge aclk) disable iff (!aresetn)
    !(!fl_oe_n && !fl_we_n))
    else $error("read and write strobe together");
  a_irq_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    st_wr && wd_q[fsp_pkg::IRQ_DONE] && !ev_done
    |=> !ist_q[fsp_pkg::IRQ_DONE])
    else $error("done status not cleared by write");

endmodule : fsp_ctrl
`default_nettype wire

// ### testbench/fsp_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module fsp_flash_model #(
  parameter int PROG_TK = 200,
  parameter int WIN_TK  = 1000,
  parameter int ERS_TK  = 400
) (
  // Flash pins
  input  wire logic [19:0] fl_addr,
  input  wire logic        fl_ce_n,
  input  wire logic        fl_oe_n,
  input  wire logic        fl_we_n,
  input  wire logic [15:0] fl_dq_o,
  input  wire logic        fl_dq_oe,
  output logic      [15:0] fl_dq_i,
  output logic             ready_busy_out,
  // Toggling stops two reads after a failure
  input  wire logic        late_stop
);
  logic [15:0] mem [16];
  logic [15:0] last_q, stat, rd, d;
  logic [31:0] esec;
  logic        prog, ers, win, fail, susp, tog, stog, pol, bad;
  int          pc, wc, ec, stops;
  wire         in_sec = esec[fl_addr[19:15]];
  wire         busy   = prog || (ers && !susp);

  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 16'hFFF7;
    {prog, ers, win, fail, susp, tog, stog, pol, bad} = '0;
    {esec, last_q, pc, wc, ec} = '0;
    stops = -1;
  end

  always_comb begin
    stat = 16'h0000;
    stat[fsp_pkg::POS_POLARITY] = susp || (prog && pol);
    stat[fsp_pkg::POS_GTOGGLE]  = tog;
    stat[fsp_pkg::POS_TIMEOUT]  = fail;
    stat[fsp_pkg::POS_WINDOW]   = win;
    stat[fsp_pkg::POS_STOGGLE]  = stog;
  end
  assign rd = (busy || (susp && in_sec)) ? stat : mem[fl_addr[3:0]];
  // A released bus never shows the last word again
  assign fl_dq_i = (!fl_ce_n && !fl_oe_n) ? rd : ~last_q;
  assign ready_busy_out = !busy;
  assign d = fl_dq_oe ? fl_dq_o : ~last_q;

  always @(negedge fl_oe_n) begin
    if (!fl_ce_n && busy && stops != 0)
      tog <= !tog;
    if (!fl_ce_n && busy && stops > 0)
      stops <= stops - 1;
    if (!fl_ce_n && ers && in_sec)
      stog <= !stog;
  end
  always @(posedge fl_oe_n)
    last_q <= rd;

  always @(posedge fl_we_n) begin
    if (!fl_ce_n) begin
      if (fail && d[7:0] == 8'hF0) begin
        fail  <= 1'h0;
        prog  <= 1'h0;
        stops <= -1;
      end else if (ers && win) begin
        if (d[7:0] == 8'hB0)
          susp <= 1'h1;
      end else if (d[7:0] == 8'h30) begin
        ers <= 1'h1;
        wc  <= WIN_TK;
        esec[fl_addr[19:15]] <= 1'h1;
      end else if (!busy && d[7:0] != 8'hF0) begin
        bad <= |(d & ~mem[fl_addr[3:0]]);
        mem[fl_addr[3:0]] <= mem[fl_addr[3:0]] & d;
        pol  <= !d[7];
        pc   <= PROG_TK;
        prog <= 1'h1;
      end
    end
  end

  // Internal timers tick every 50 ns, at the same instants as the aclk falling edges
  always #50 begin
    if (prog && !fail && pc > 0)
      pc <= pc - 1;
    else if (prog && !fail && bad) begin
      fail  <= 1'h1;
      stops <= late_stop ? 2 : -1;
    end else if (prog && !fail)
      prog <= 1'h0;
    if (ers && !win && wc > 0)
      wc <= wc - 1;
    else if (ers && !win) begin
      win <= 1'h1;
      ec  <= ERS_TK;
    end else if (ers && !susp && ec > 0)
      ec <= ec - 1;
    else if (ers && !susp)
      {ers, win, esec} <= '0;
  end
endmodule : fsp_flash_model
`default_nettype wire

// ### testbench/flash_write_status_reporting_bench.sv
`timescale 1ns/100ps
`default_nettype none
module flash_write_status_reporting_bench;
  logic        aclk, aresetn, irq, late_stop;
  logic [7:0]  s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, v;
  logic [3:0]  s_wstrb;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready;
  logic [1:0]  s_bresp, s_rresp;
  logic [19:0] fl_addr;
  logic [15:0] fl_dq_o, fl_dq_i;
  logic        fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe, ready_busy_out;
  int          fails, tests_run;

  fsp_ctrl i_dut (
    .aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
    .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
    .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
    .s_rready, .irq, .fl_addr, .fl_ce_n, .fl_oe_n, .fl_we_n, .fl_dq_o,
    .fl_dq_oe, .fl_dq_i, .ready_busy_out
  );
  fsp_flash_model i_flash (
    .fl_addr, .fl_ce_n, .fl_oe_n, .fl_we_n, .fl_dq_o, .fl_dq_oe,
    .fl_dq_i, .ready_busy_out, .late_stop
  );

  initial begin
    aclk = 1'h0;
    forever #25 aclk = !aclk;
  end

  // ************************
  // Bus tasks
  // ************************
  task automatic chk(input string n, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    {aw, w, b} = 3'h0;
    @(posedge aclk);
    s_awaddr  <= a;
    s_wdata   <= d;
    s_awvalid <= 1'h1;
    s_wvalid  <= 1'h1;
    s_bready  <= 1'h1;
    while (!b) begin
      @(posedge aclk);
      b = aw && w && s_bvalid === 1'h1;
      if (s_awready === 1'h1 && !aw) begin
        aw = 1'h1;
        s_awvalid <= 1'h0;
      end
      if (s_wready === 1'h1 && !w) begin
        w = 1'h1;
        s_wvalid <= 1'h0;
      end
    end
    s_bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic ar, r;
    {ar, r} = 2'h0;
    @(posedge aclk);
    s_araddr  <= a;
    s_arvalid <= 1'h1;
    s_rready  <= 1'h1;
    while (!r) begin
      @(posedge aclk);
      if (s_rvalid === 1'h1 && ar) begin
        r = 1'h1;
        d = s_rdata;
        s_rready <= 1'h0;
      end
      if (s_arready === 1'h1 && !ar) begin
        ar = 1'h1;
        s_arvalid <= 1'h0;
      end
    end
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] e, string n);
    rd(a, v);
    chk(n, e, v);
  endtask : rc

  task automatic st(input logic [31:0] e, m, input string n);
    rd(fsp_pkg::OFF_STATUS, v);
    chk(n, e, v & m);
  endtask : st

  // Control writes are ignored while busy, so every command waits
  task automatic cmd(input logic [2:0] c);
    int k;
    wr(fsp_pkg::OFF_CTRL, {29'h0000_0000, c});
    k = 0;
    do begin
      rd(fsp_pkg::OFF_STATUS, v);
      k++;
    end while (v[0] !== 1'h0 && k < 60);
    chk("command finished", 32'h0, {31'h0, v[0]});
  endtask : cmd

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    $display("Watchdog expired");
    test_done();
  end

  // ************************
  // Tests
  // ************************
  initial begin
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, late_stop} = '0;
    {s_awaddr, s_araddr, s_wdata} = '0;
    s_wstrb = 4'hF;
    {fails, tests_run} = '0;
    aresetn = 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rc(fsp_pkg::OFF_STATUS, fsp_pkg::RST_ZERO, "status reset");
    rc(fsp_pkg::OFF_IRQ_ST, fsp_pkg::RST_ZERO, "irq status reset");
    rc(fsp_pkg::OFF_IRQ_MK, fsp_pkg::RST_ZERO, "irq mask reset");
    rc(8'h1C, fsp_pkg::RST_ZERO, "unmapped read");
    wr(fsp_pkg::OFF_ADDR, 32'h0000_0003);
    cmd(fsp_pkg::CMD_READ);
    rc(fsp_pkg::OFF_RDATA, 32'h0000_FFF7, "array read");
    $display("test reset_and_read finished");
    wr(fsp_pkg::OFF_WDATA, 32'h0000_00A5);
    cmd(fsp_pkg::CMD_WRITE);
    cmd(fsp_pkg::CMD_POLL);
    st(32'h0000_000A, 32'h0000_000E, "program busy");
    repeat (250) @(posedge aclk);
    cmd(fsp_pkg::CMD_POLL);
    st(32'h0000_0000, 32'h0000_000E, "program done");
    rc(fsp_pkg::OFF_IRQ_ST, 32'h0000_0001, "done event");
    chk("irq masked", 32'h0, {31'h0, irq});
    cmd(fsp_pkg::CMD_READ);
    rc(fsp_pkg::OFF_RDATA, 32'h0000_00A5, "programmed word");
    wr(fsp_pkg::OFF_IRQ_ST, 32'h0000_0007);
    $display("test program finished");
    wr(fsp_pkg::OFF_WDATA, 32'h0000_00FF);
    cmd(fsp_pkg::CMD_WRITE);
    repeat (250) @(posedge aclk);
    cmd(fsp_pkg::CMD_POLL);
    st(32'h0000_000E, 32'h0000_000E, "program fail");
    rc(fsp_pkg::OFF_IRQ_ST, 32'h0000_0002, "fail event");
    wr(fsp_pkg::OFF_IRQ_MK, 32'h0000_0002);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(fsp_pkg::OFF_IRQ_ST, 32'h0000_0002);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(fsp_pkg::OFF_WDATA, 32'h0000_00F0);
    cmd(fsp_pkg::CMD_WRITE);
    cmd(fsp_pkg::CMD_POLL);
    st(32'h0000_0000, 32'h0000_000E, "after reset command");
    late_stop <= 1'h1;
    wr(fsp_pkg::OFF_WDATA, 32'h0000_00FF);
    cmd(fsp_pkg::CMD_WRITE);
    repeat (250) @(posedge aclk);
    cmd(fsp_pkg::CMD_POLL);
    st(32'h0000_0000, 32'h0000_000C, "late stop recheck");
    wr(fsp_pkg::OFF_WDATA, 32'h0000_00F0);
    cmd(fsp_pkg::CMD_WRITE);
    $display("test failure finished");
    wr(fsp_pkg::OFF_WDATA, 32'h0000_0030);
    for (int i = 3; i < 6; i++) begin
      wr(fsp_pkg::OFF_ADDR, {12'h000, i[4:0], 15'h0000});
      cmd(fsp_pkg::CMD_ERASE);
      st(32'h0, 32'h0000_0030, "erase accepted");
      repeat (600) @(posedge aclk);
    end
    cmd(fsp_pkg::CMD_POLL);
    st(32'h0000_000A, 32'h0000_001E, "erase busy");
    repeat (500) @(posedge aclk);
    wr(fsp_pkg::OFF_IRQ_ST, 32'h0000_0007);
    wr(fsp_pkg::OFF_ADDR, 32'h0003_0000);
    cmd(fsp_pkg::CMD_ERASE);
    st(32'h0000_0030, 32'h0000_0030, "erase rejected");
    rc(fsp_pkg::OFF_IRQ_ST, 32'h0000_0004, "reject event");
    wr(fsp_pkg::OFF_ADDR, 32'h0001_8000);
    wr(fsp_pkg::OFF_WDATA, 32'h0000_00B0);
    cmd(fsp_pkg::CMD_WRITE);
    cmd(fsp_pkg::CMD_POLL);
    st(32'h0000_0000, 32'h0000_000E, "suspended");
    $display("test erase finished");
    test_done();
  end
endmodule : flash_write_status_reporting_bench
`default_nettype wire
